// ### updown_autoreload_timer.sv
// 16-bit up/down auto-reload timer/counter with 17th toggle bit.
// Assumes pins synchronous to clk_in; software writes via plain ports.
// How it works
// - Count is a low byte and high byte in cascade; low carry advances high.
// - Source select picks clock divided by twelve or the external count pin.
// - Low byte advances from the chosen source only while run bit is set.
// - Mode from receive, transmit and capture/reload selects: capture, reload, baud.
// - Reload mode with up/down disabled counts up and reloads on overflow.
// - Reload mode with up/down enabled takes direction from the direction pin.
// - Direction high counts up; passing FFFF sets overflow flag and interrupt.
// - Up overflow loads the reload bytes into the count bytes.
// - Direction low counts down; underflow when count equals the reload value.
// - Down underflow sets the overflow flag and loads FFFF into count.
// - Up/down mode toggles the toggle flag on each wrap, never interrupting.
// - Overflow flag set only when both serial clock selects are zero.
// - Counter operation advances on each falling edge of the count pin.
`timescale 1ns/1ps
module updown_autoreload_timer
   import updown_timer_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Control bits
   input wire logic run_control_bit_in,
   input wire logic count_source_select_in,
   input wire logic updown_enable_bit_in,
   input wire logic receive_clock_select_in,
   input wire logic transmit_clock_select_in,
   input wire logic capture_reload_select_in,
   // Software writes
   input wire logic count_low_wr_in,
   input wire logic count_high_wr_in,
   input wire logic reload_low_wr_in,
   input wire logic reload_high_wr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic overflow_flag_clr_in,
   input wire logic toggle_flag_clr_in,
   // Pins
   input wire logic external_count_pin_in,
   input wire logic direction_input_pin_in,
   // Status
   output logic [7:0] count_low_byte_out,
   output logic [7:0] count_high_byte_out,
   output logic [7:0] reload_low_byte_out,
   output logic [7:0] reload_high_byte_out,
   output logic overflow_flag_out,
   output logic toggle_flag_out,
   output logic irq_out
);

   typedef struct packed {
      logic [3:0] prescale;
      logic pin_last;
      logic [7:0] count_low_byte;
      logic [7:0] count_high_byte;
      logic [7:0] reload_low_byte;
      logic [7:0] reload_high_byte;
      logic overflow_flag;
      logic toggle_flag;
      logic irq;
   } state_s;

   state_s cur;
   state_s next_cur;

   function automatic timer_mode_e decode_mode(input logic rx, input logic tx,
                                               input logic cp);
      if (rx || tx) begin
         return MODE_BAUD;
      end
      return cp ? MODE_CAPTURE : MODE_RELOAD;
   endfunction : decode_mode

   logic tick;
   logic [15:0] count;
   logic [15:0] reload;
   logic [15:0] stepped;
   logic wrap;
   logic count_up;
   timer_mode_e mode;

   always_comb begin
      next_cur = cur;
      tick = 1'b0;
      count = {cur.count_high_byte, cur.count_low_byte};
      reload = {cur.reload_high_byte, cur.reload_low_byte};
      mode = decode_mode(receive_clock_select_in, transmit_clock_select_in,
                         capture_reload_select_in);
      count_up = 1'b1;
      wrap = 1'b0;
      stepped = count;
      next_cur.pin_last = external_count_pin_in;
      if (run_control_bit_in) begin
         // Divider only runs with the timer so a stop freezes phase
         if (cur.prescale == PRESCALE_LAST) begin
            next_cur.prescale = 4'h0;
         end else begin
            next_cur.prescale = cur.prescale + 4'h1;
         end
      end
      if (count_source_select_in) begin
         tick = cur.pin_last && !external_count_pin_in;
      end else begin
         tick = cur.prescale == PRESCALE_LAST;
      end
      if (mode == MODE_RELOAD && updown_enable_bit_in) begin
         count_up = direction_input_pin_in;
      end
      if (run_control_bit_in && tick) begin
         if (count_up) begin
            wrap = count == COUNT_TOP;
            stepped = wrap ? reload : count + 16'h0001;
         end else begin
            wrap = count == reload;
            stepped = wrap ? COUNT_TOP : count - 16'h0001;
         end
         next_cur.count_low_byte = stepped[7:0];
         next_cur.count_high_byte = stepped[15:8];
      end
      // Software writes override the step in the same cycle
      if (count_low_wr_in) begin
         next_cur.count_low_byte = wr_data_in;
      end
      if (count_high_wr_in) begin
         next_cur.count_high_byte = wr_data_in;
      end
      if (reload_low_wr_in) begin
         next_cur.reload_low_byte = wr_data_in;
      end
      if (reload_high_wr_in) begin
         next_cur.reload_high_byte = wr_data_in;
      end
      // Flag clears lose to a same-cycle set
      if (overflow_flag_clr_in) begin
         next_cur.overflow_flag = 1'b0;
      end
      if (toggle_flag_clr_in) begin
         next_cur.toggle_flag = 1'b0;
      end
      // Any wrap outside baud use sets the flag, capture included
      if (wrap && mode != MODE_BAUD) begin
         next_cur.overflow_flag = 1'b1;
         if (updown_enable_bit_in && mode == MODE_RELOAD) begin
            next_cur.toggle_flag = !cur.toggle_flag;
         end
      end
      // Toggle flag never interrupts in up/down mode
      next_cur.irq = next_cur.overflow_flag ||
                     (next_cur.toggle_flag && !updown_enable_bit_in);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cur <= '0;
         cur.count_low_byte <= COUNT_RESET[7:0];
         cur.count_high_byte <= COUNT_RESET[15:8];
         cur.reload_low_byte <= RELOAD_RESET[7:0];
         cur.reload_high_byte <= RELOAD_RESET[15:8];
         cur.pin_last <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign count_low_byte_out = cur.count_low_byte;
   assign count_high_byte_out = cur.count_high_byte;
   assign reload_low_byte_out = cur.reload_low_byte;
   assign reload_high_byte_out = cur.reload_high_byte;
   assign overflow_flag_out = cur.overflow_flag;
   assign toggle_flag_out = cur.toggle_flag;
   assign irq_out = cur.irq;

endmodule : updown_autoreload_timer

// ### updown_timer_pkg.sv
// Constants for the up/down auto-reload timer.
// Assumes one 250 MHz clock; pins already synchronous to it.
package updown_timer_pkg;
   localparam int unsigned PRESCALE_DIV = 12;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
   typedef enum logic [1:0] {
      MODE_RELOAD = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_BAUD = 2'b11
   } timer_mode_e;
endpackage : updown_timer_pkg

// ### updown_timer_props.sv
// Checker for the up/down timer, bound to its ports.
// Assumes synchronous reset rst_in on clk_in.
`timescale 1ns/1ps
module updown_timer_props (
   input wire logic clk_in, rst_in, run_control_bit_in,
   input wire logic count_source_select_in, updown_enable_bit_in,
   input wire logic receive_clock_select_in, transmit_clock_select_in,
   input wire logic count_low_wr_in, count_high_wr_in,
   input wire logic overflow_flag_clr_in, toggle_flag_clr_in,
   input wire logic external_count_pin_in, direction_input_pin_in,
   input wire logic [7:0] count_low_byte_out, count_high_byte_out,
   input wire logic [7:0] reload_low_byte_out, reload_high_byte_out,
   input wire logic overflow_flag_out, toggle_flag_out, irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire [15:0] cnt = {count_high_byte_out, count_low_byte_out};
   sequence s_wrap; $rose(overflow_flag_out); endsequence
   property p_up; s_wrap ##0 $past(cnt) == 16'hFFFF |->
      cnt == {reload_high_byte_out, reload_low_byte_out}; endproperty
   property p_dn; s_wrap ##0 $past(updown_enable_bit_in) &&
      !$past(direction_input_pin_in) |-> cnt == 16'hFFFF; endproperty
   property p_irq; updown_enable_bit_in && $stable(updown_enable_bit_in)
      |-> irq_out == overflow_flag_out; endproperty
   property p_tog; $changed(toggle_flag_out) && !$past(toggle_flag_clr_in)
      |-> $past(updown_enable_bit_in) && overflow_flag_out; endproperty
   property p_set; s_wrap |-> !$past(receive_clock_select_in) &&
      !$past(transmit_clock_select_in); endproperty
   property p_clr; $fell(overflow_flag_out) |->
      $past(overflow_flag_clr_in); endproperty
   property p_hold; !run_control_bit_in && !count_low_wr_in &&
      !count_high_wr_in |=> $stable(cnt); endproperty
   property p_edge; $changed(count_low_byte_out) &&
      $past(count_source_select_in) && !$past(count_low_wr_in) |->
      $past(external_count_pin_in, 2) && !$past(external_count_pin_in);
   endproperty
   a_up: assert property (p_up) else $error("no reload on overflow");
   a_dn: assert property (p_dn) else $error("no FFFF on underflow");
   a_irq: assert property (p_irq) else $error("irq mismatch");
   a_tog: assert property (p_tog) else $error("stray toggle");
   a_set: assert property (p_set) else $error("flag set in baud");
   a_clr: assert property (p_clr) else $error("flag fell alone");
   a_hold: assert property (p_hold) else $error("count moved");
   a_edge: assert property (p_edge) else $error("count off edge");
endmodule : updown_timer_props

// ### ext_count_model.sv
// Model of the external count pin source.
// Assumes pulse_in changes just after a rising edge.
`timescale 1ns/1ps
module ext_count_model (
   input wire logic clk_in,
   input wire logic pulse_in,
   output logic pin_out
);
   initial pin_out = 1'b1;
   // Pulled up; low one cycle per event
   always @(posedge clk_in) pin_out <= !pulse_in;
endmodule : ext_count_model

// ### updown_autoreload_timer_tb.sv
// Testbench for the up/down auto-reload timer.
// Assumes the external count model beside it.
`timescale 1ns/1ps
module updown_autoreload_timer_tb;
   import updown_timer_pkg::*;
   logic clk_in = 0, rst_in = 1, run_control_bit_in = 0, pulse = 0;
   logic count_source_select_in = 0, updown_enable_bit_in = 0;
   logic receive_clock_select_in = 0, transmit_clock_select_in = 0;
   logic capture_reload_select_in = 0, count_low_wr_in = 0;
   logic count_high_wr_in = 0, reload_low_wr_in = 0, reload_high_wr_in = 0;
   logic overflow_flag_clr_in = 0, toggle_flag_clr_in = 0;
   logic direction_input_pin_in = 1;
   logic [7:0] wr_data_in = 0;
   logic [7:0] count_low_byte_out, count_high_byte_out;
   logic [7:0] reload_low_byte_out, reload_high_byte_out;
   logic overflow_flag_out, toggle_flag_out, irq_out, external_count_pin_in;
   int miscompares = 0, total_checks = 0, cyc = 0;
   updown_autoreload_timer updown_autoreload_timer_inst (.*);
   ext_count_model ext_count_model_inst (.clk_in(clk_in),
      .pulse_in(pulse), .pin_out(external_count_pin_in));
   initial forever #2 clk_in = ~clk_in;
   task automatic tick(int n); repeat (n) @(posedge clk_in); #1;
   endtask : tick
   task automatic wr(bit rl, logic [15:0] v);
      wr_data_in = v[7:0]; reload_low_wr_in = rl; count_low_wr_in = !rl;
      tick(1);
      {reload_low_wr_in, count_low_wr_in} = 2'h0;
      wr_data_in = v[15:8]; reload_high_wr_in = rl; count_high_wr_in = !rl;
      tick(1);
      {reload_high_wr_in, count_high_wr_in} = 2'h0;
   endtask : wr
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wait_of;
      for (int i = 0; i < 40 && overflow_flag_out !== 1'b1; i++) tick(1);
   endtask : wait_of
   task automatic clr_of;
      overflow_flag_clr_in = 1; tick(1); overflow_flag_clr_in = 0;
   endtask : clr_of
   task automatic test_done;
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   always @(posedge clk_in) if (++cyc > 2000) begin
      miscompares++;
      test_done;
   end
   initial begin
      tick(10); rst_in = 0;
      wr(1, 16'h1234); wr(0, 16'hFFFE);
      updown_enable_bit_in = 1; run_control_bit_in = 1;
      wait_of;
      chk("up", {count_high_byte_out, count_low_byte_out}, 16'h1234);
      chk("flags", {overflow_flag_out, toggle_flag_out, irq_out}, 3'h7);
      run_control_bit_in = 0; direction_input_pin_in = 0; clr_of; tick(30);
      chk("hold", {count_high_byte_out, count_low_byte_out}, 16'h1234);
      chk("clr", overflow_flag_out, 1'b0);
      run_control_bit_in = 1; wait_of;
      chk("down", {count_high_byte_out, count_low_byte_out}, 16'hFFFF);
      chk("tog", toggle_flag_out, 1'b0);
      count_source_select_in = 1; clr_of; tick(30);
      pulse = 1; tick(1); pulse = 0; tick(3);
      chk("pin", {count_high_byte_out, count_low_byte_out}, 16'hFFFE);
      receive_clock_select_in = 1; direction_input_pin_in = 1;
      updown_enable_bit_in = 0; wr(0, 16'hFFFF);
      pulse = 1; tick(1); pulse = 0; tick(3);
      chk("baud", overflow_flag_out, 1'b0);
      chk("reload", {reload_high_byte_out, reload_low_byte_out}, 16'h1234);
      receive_clock_select_in = 0; capture_reload_select_in = 1;
      wr(0, 16'hFFFF);
      pulse = 1; tick(1); pulse = 0; tick(3);
      chk("capture", {overflow_flag_out, irq_out}, 2'h3);
      test_done;
   end
endmodule : updown_autoreload_timer_tb
bind updown_autoreload_timer updown_timer_props props_inst (.*);
